//--- adc_sleep_noise_canceler_control.sv
// converter control with sleep-triggered conversion and wishbone registers
//
// Contract
// R1: software enables the converter, leaves it idle, picks single mode and unmasks the done interrupt before sleeping.
// R2: entering noise-reduction or idle sleep under those conditions starts a conversion once the core has halted.
// R3: if nothing else wakes the core first, the conversion-complete event wakes it.
// R4: if another interrupt wakes the core first, the conversion still finishes and still raises its done request.
// R5: after waking the core stays active and no new sleep conversion happens until a new sleep command.
// R6: other sleep modes leave the converter enable untouched.
// R7: software should toggle the enable after such a sleep before differential conversions.
// R8: both differential input selects are free, so the same input may drive both for offset measurement.
// R9: pins shared with converter inputs must not toggle during a conversion.
// R10: a software start begins on the next converter clock edge after the write; a start written with the enable while disabled is dropped.
// R11: a sleep start happens once per sleep entry and sets the done flag like a software start.
`include "adc_sleep_cfg.svh"
`default_nettype none
module adc_sleep_noise_canceler_control
  import adc_sleep_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire sleep_mode_t sleep_mode_i,
  input  wire logic        cpu_halted_i,
  input  wire logic [9:0]  sample_i,
  output logic             hold_o,
  output logic      [4:0]  mux_pos_o,
  output logic      [4:0]  mux_neg_o,
  output logic             wake_o,
  output logic             irq_o
);
  // ************************************************************
  // state
  // ************************************************************
  logic       enable;
  logic       free_run;
  logic       start_pend;
  logic       first_done;
  logic       in_sleep_conv;
  logic       halted_q;
  logic [2:0] div_cnt;
  logic [4:0] tick_cnt;
  logic [1:0] status;
  logic [1:0] mask;
  logic [9:0] result;
  logic [9:0] sample_meta;
  logic [9:0] sample_sync;

  // ************************************************************
  // bus decode
  // ************************************************************
  wire acc      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr       = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o; // ack edge
  wire wr_ctrl  = wr & (wb_adr_i == `OFS_CTRL) & wb_sel_i[0];
  wire wr_pos   = wr & (wb_adr_i == `OFS_MUX) & wb_sel_i[0];
  wire wr_neg   = wr & (wb_adr_i == `OFS_MUX) & wb_sel_i[1];
  wire wr_stat  = wr & (wb_adr_i == `OFS_STATUS) & wb_sel_i[0];
  wire wr_mask  = wr & (wb_adr_i == `OFS_MASK) & wb_sel_i[0];
  wire [1:0] status_clr = wr_stat ? wb_dat_i[1:0] : 2'h0;
  wire busy     = (tick_cnt != 5'h00);
  wire [31:0] ctrl_rd = {28'h0000000, busy, free_run,
                         start_pend | busy, enable};
  wire [31:0] mux_rd  = {19'h00000, mux_neg_o, 3'h0, mux_pos_o};
  wire [31:0] rd_data =
    (wb_adr_i == `OFS_CTRL)   ? ctrl_rd :
    (wb_adr_i == `OFS_MUX)    ? mux_rd :
    (wb_adr_i == `OFS_STATUS) ? {30'h00000000, status} :
    (wb_adr_i == `OFS_MASK)   ? {30'h00000000, mask} :
    (wb_adr_i == `OFS_RESULT) ? {22'h000000, result} : 32'h00000000;

  // ************************************************************
  // converter clock, starts and completion
  // ************************************************************
  wire tick      = enable & (div_cnt == 3'(`DIV_CYCLES - 1));
  wire sw_start  = wr_ctrl & wb_dat_i[`CTRL_START] & wb_dat_i[`CTRL_ENABLE];
  wire qual_mode = (sleep_mode_i == SLP_IDLE) | (sleep_mode_i == SLP_NOISE);
  wire halt_rise = cpu_halted_i & ~halted_q;              // [R5]
  // only the first halted cycle of a sleep can trigger, so one per entry
  wire sleep_trig = halt_rise & qual_mode & enable & ~busy & ~start_pend
                    & ~free_run & mask[`ST_DONE];          // [R2] [R11]
  wire begin_conv = start_pend & tick;                     // [R10]
  wire done       = tick & (tick_cnt == 5'h01);
  wire [4:0] conv_len = first_done ? 5'(`CONV_TICKS) : 5'(`FIRST_TICKS);
  wire [1:0] status_set = {done & in_sleep_conv, done};    // [R11]
  wire [1:0] next_status = (status & ~status_clr) | status_set;

  // bus answer one cycle after the request, read data latched with it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= acc;
      wb_dat_o <= acc ? rd_data : 32'h00000000;
    end
  end

  // control fields; sleep entry never touches the enable
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      enable   <= 1'b0;
      free_run <= 1'b0;
      mask     <= `RST_MASK;
    end
    else
    begin
      if (wr_ctrl)
      begin
        enable   <= wb_dat_i[`CTRL_ENABLE];                // [R6]
        free_run <= wb_dat_i[`CTRL_FREE];
      end
      if (wr_mask)
        mask <= wb_dat_i[1:0];
    end
  end

  // channel selects, any pair allowed including equal inputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mux_pos_o <= `RST_MUX;
      mux_neg_o <= `RST_MUX;
    end
    else
    begin
      if (wr_pos)
        mux_pos_o <= wb_dat_i[`MUX_POS_LSB +: 5];          // [R8]
      if (wr_neg)
        mux_neg_o <= wb_dat_i[`MUX_NEG_LSB +: 5];          // [R8]
    end
  end

  // sample input from the analog front end, two-stage synchroniser
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sample_meta <= 10'h000;
      sample_sync <= 10'h000;
    end
    else
    begin
      sample_meta <= sample_i;
      sample_sync <= sample_meta;
    end
  end

  // divider and conversion sequencer; disabling aborts everything
  always_ff @(posedge clk_i)
  begin
    if (rst_i | ~enable)
    begin
      div_cnt    <= 3'h0;
      tick_cnt   <= 5'h00;
      start_pend <= 1'b0;
      hold_o     <= 1'b0;
      first_done <= rst_i ? 1'b0 : first_done & enable;
    end
    else
    begin
      div_cnt <= tick ? 3'h0 : div_cnt + 3'h1;
      if (sw_start | sleep_trig)
        start_pend <= 1'b1;
      else if (begin_conv)
        start_pend <= 1'b0;
      if (begin_conv)
      begin
        tick_cnt <= conv_len;                              // [R10]
        hold_o   <= 1'b1;
      end
      else if (done & free_run)
        tick_cnt <= 5'(`CONV_TICKS);
      else if (tick & busy)
      begin
        tick_cnt <= tick_cnt - 5'h01;
        hold_o   <= ~done;
      end
      if (done)
        first_done <= 1'b1;
    end
  end

  // result, sleep bookkeeping and wake pulse
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      result        <= 10'h000;
      halted_q      <= 1'b0;
      in_sleep_conv <= 1'b0;
      wake_o        <= 1'b0;
    end
    else
    begin
      halted_q <= cpu_halted_i;
      if (done)
        result <= sample_sync;
      if (sleep_trig)
        in_sleep_conv <= 1'b1;
      else if (done | ~enable)
        in_sleep_conv <= 1'b0;
      // a core already woken by another source gets no second wake
      wake_o <= done & in_sleep_conv & cpu_halted_i;       // [R3] [R4]
    end
  end

  // sticky status, set wins over write-one-to-clear; masked interrupt
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      status <= 2'h0;
      irq_o  <= 1'b0;
    end
    else
    begin
      status <= next_status;                               // [R4]
      irq_o  <= |(next_status & mask);                     // [R3]
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_start_on_tick;
    begin_conv |=> busy && hold_o;
  endproperty
  a_start_on_tick: assert property (p_start_on_tick) // [R10]
    else $error("pending start did not begin on converter edge");

  property p_begin_needs_tick;
    $rose(hold_o) |-> $past(tick) && $past(start_pend);
  endproperty
  a_begin_needs_tick: assert property (p_begin_needs_tick) // [R10]
    else $error("conversion began off a converter edge");

  property p_sleep_start;
    sleep_trig |=> start_pend ##[1:4] hold_o;
  endproperty
  a_sleep_start: assert property (p_sleep_start) // [R2]
    else $error("sleep entry did not start a conversion");

  property p_done_flag;
    done |=> status[`ST_DONE] && result == $past(sample_sync);
  endproperty
  a_done_flag: assert property (p_done_flag) // [R11]
    else $error("completion did not set flag and result");

  property p_wake;
    done && in_sleep_conv && cpu_halted_i |=> wake_o ##1 irq_o;
  endproperty
  a_wake: assert property (p_wake) // [R3]
    else $error("sleep conversion did not wake the core");

  property p_other_wake;
    done && in_sleep_conv && !cpu_halted_i |=> !wake_o && status == 2'h3;
  endproperty
  a_other_wake: assert property (p_other_wake) // [R4]
    else $error("early wake lost the completion request");

  property p_once;
    $rose(in_sleep_conv) |-> $past(cpu_halted_i) && !$past(cpu_halted_i, 2);
  endproperty
  a_once: assert property (p_once) // [R5] [R11]
    else $error("second sleep conversion in one sleep");

  property p_enable_kept;
    $rose(cpu_halted_i) && !qual_mode && !wr_ctrl |=> enable == $past(enable);
  endproperty
  a_enable_kept: assert property (p_enable_kept) // [R6]
    else $error("sleep entry changed the converter enable");

  property p_same_input;
    wr_pos && wr_neg |=> mux_pos_o == $past(wb_dat_i[4:0])
                         && mux_neg_o == $past(wb_dat_i[12:8]);
  endproperty
  a_same_input: assert property (p_same_input) // [R8]
    else $error("channel selects not stored as written");
endmodule
`default_nettype wire

//--- adc_sleep_cfg.svh
// offsets, field positions, reset values and timing counts of the block
`ifndef ADC_SLEEP_CFG_SVH
`define ADC_SLEEP_CFG_SVH
// ************************************************************
// register byte offsets
// ************************************************************
`define OFS_CTRL        5'h00
`define OFS_MUX         5'h04
`define OFS_STATUS      5'h08
`define OFS_MASK        5'h0C
`define OFS_RESULT      5'h10
// ************************************************************
// field positions
// ************************************************************
`define CTRL_ENABLE     0
`define CTRL_START      1
`define CTRL_FREE       2
`define CTRL_BUSY       3
`define MUX_POS_LSB     0
`define MUX_NEG_LSB     8
`define ST_DONE         0
`define ST_WAKE         1
// ************************************************************
// reset values
// ************************************************************
`define RST_MUX         5'h00
`define RST_MASK        2'h0
// ************************************************************
// timing: converter clock derived from the system clock
// ************************************************************
`define CLK_PERIOD_NS   50
`define CONV_PERIOD_NS  200
`define DIV_CYCLES      (`CONV_PERIOD_NS / `CLK_PERIOD_NS)
`define CONV_TICKS      13
`define FIRST_TICKS     25
`endif

//--- adc_sleep_pkg.sv
// types shared by the sleep conversion control block
`default_nettype none
package adc_sleep_pkg;
  // sleep mode as announced by the core, in this code order
  typedef enum logic [2:0]
  {
    SLP_IDLE,
    SLP_NOISE,
    SLP_PDOWN,
    SLP_PSAVE,
    SLP_STANDBY,
    SLP_EXT_STANDBY
  } sleep_mode_t;
endpackage
`default_nettype wire

//--- cpu_core_model.sv
// behavioural core that sleeps on command and wakes on interrupts
`default_nettype none
module cpu_core_model
  import adc_sleep_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        go_i,
  input  wire sleep_mode_t mode_i,
  input  wire logic        ext_irq_i,
  input  wire logic        wake_i,
  output var sleep_mode_t  sleep_mode_o,
  output var logic         cpu_halted_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // halt on a sleep command, resume on any wake source
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sleep_mode_o <= SLP_IDLE;
      cpu_halted_o <= 1'b0;
    end
    else if (go_i)
    begin
      sleep_mode_o <= mode_i; // bench sets enable and mask first, and single mode for all but the free-run refusal sleep
      cpu_halted_o <= 1'b1;
    end
    else if (wake_i || ext_irq_i)
      cpu_halted_o <= 1'b0; // stays active until a new command
  end
endmodule
`default_nettype wire

//--- adc_sleep_noise_canceler_control_tb.sv
// self-checking bench for the sleep conversion control block
`include "adc_sleep_cfg.svh"
`default_nettype none
module adc_sleep_noise_canceler_control_tb
  import adc_sleep_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, go = 0, ext = 0;
  logic [4:0]  adr = 0;
  logic [31:0] wdat = 0, rdat;
  sleep_mode_t mode = SLP_IDLE, core_mode;
  logic        halted, ack, hold, wake, irq, hold_q;
  logic [31:0] dat_o;
  logic [4:0]  mpos, mneg;
  logic [9:0]  smp = 10'h2A5;
  int          err_count = 0, samples_checked = 0, cycles = 0;
  int          wakes = 0, rises = 0, w0, r0;
  adc_sleep_noise_canceler_control i_adc_sleep_noise_canceler_control (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .sleep_mode_i(core_mode), .cpu_halted_i(halted),
    .sample_i(smp), .hold_o(hold), .mux_pos_o(mpos), .mux_neg_o(mneg),
    .wake_o(wake), .irq_o(irq));
  cpu_core_model i_cpu_core_model (
    .clk_i(clk), .rst_i(rst), .go_i(go), .mode_i(mode), .ext_irq_i(ext),
    .wake_i(wake), .sleep_mode_o(core_mode), .cpu_halted_o(halted));
  always #25 clk = ~clk;
  // cycle count, wake pulses, conversion starts and the hang limit
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    hold_q <= hold;
    if (wake === 1'b1) wakes <= wakes + 1;
    if (hold === 1'b1 && hold_q === 1'b0) rises <= rises + 1;
    if (cycles == 20000)
    begin
      err_count++;
      print_verdict();
    end
  end
  task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // one classic wishbone cycle, held until ack is sampled
  task automatic wb(logic w, logic [4:0] a, logic [31:0] d);
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 0;
    stb <= 0;
  endtask
  task automatic rd(string n, logic [4:0] a, logic [31:0] exp);
    wb(0, a, 0);
    check(n, rdat, exp);
  endtask
  task automatic wait_hold(logic v);
    for (int i = 0; i < 300 && hold !== v; i++) @(posedge clk);
    check("hold_o", hold, v);
  endtask
  // clock cycles that hold_o stays high for one conversion
  task automatic conv_time(output int n);
    wait_hold(1);
    for (n = 0; n < 300 && hold === 1'b1; n++) @(posedge clk);
  endtask
  task automatic pulse_sleep(sleep_mode_t m);
    @(posedge clk);
    mode <= m;
    go <= 1;
    @(posedge clk);
    go <= 0;
  endtask
  task automatic pulse_ext();
    @(posedge clk);
    ext <= 1;
    @(posedge clk);
    ext <= 0;
  endtask
  task automatic soft_start_irq();
    rd("mux", `OFS_MUX, 0);
    rd("mask", `OFS_MASK, 0);
    rd("unmapped", 5'h14, 0);
    wb(1, `OFS_CTRL, 32'h1);
    wb(1, `OFS_CTRL, 32'h3);
    wait_hold(1);
    wait_hold(0);
    rd("status", `OFS_STATUS, 1);
    rd("result", `OFS_RESULT, 32'h2A5);
    check("irq masked", irq, 0);
    wb(1, `OFS_MASK, 32'h1);
    repeat (2) @(posedge clk); // mask lands at ack, irq one edge later
    check("irq", irq, 1);
    wb(1, `OFS_STATUS, 32'h1);
    @(posedge clk);
    check("irq cleared", irq, 0);
    $display("test soft_start_irq done");
  endtask
  task automatic noise_sleep_wake();
    pulse_sleep(SLP_NOISE);
    wait_hold(1);
    wait_hold(0);
    repeat (3) @(posedge clk);
    check("halted", halted, 0);
    check("wakes", wakes, 1);
    r0 = rises;
    repeat (150) @(posedge clk);
    check("no restart", rises, r0);
    rd("status", `OFS_STATUS, 3);
    wb(1, `OFS_STATUS, 32'h3);
    $display("test noise_sleep_wake done");
  endtask
  task automatic other_irq_first();
    w0 = wakes;
    pulse_sleep(SLP_IDLE);
    wait_hold(1);
    pulse_ext();
    wait_hold(0);
    repeat (3) @(posedge clk);
    check("no wake", wakes, w0);
    rd("status", `OFS_STATUS, 3);
    check("irq", irq, 1);
    wb(1, `OFS_STATUS, 32'h3);
    $display("test other_irq_first done");
  endtask
  task automatic other_modes();
    r0 = rises;
    for (int m = SLP_PDOWN; m <= SLP_EXT_STANDBY; m++)
    begin
      pulse_sleep(sleep_mode_t'(m));
      repeat (120) @(posedge clk);
      check("no start", rises, r0);
      pulse_ext();
      rd("ctrl enable", `OFS_CTRL, 1);
    end
    wb(1, `OFS_MUX, 32'h0505);
    @(posedge clk);
    check("mux pos", mpos, 5);
    check("mux neg", mneg, 5);
    $display("test other_modes done");
  endtask
  // conversion lengths, enable toggle, new sample and free-run refusal
  task automatic restart_after_sleep();
    int n;
    wb(1, `OFS_CTRL, 32'h3);
    conv_time(n);
    check("plain length", n, `CONV_TICKS * `DIV_CYCLES);
    wb(1, `OFS_CTRL, 32'h0);
    wb(1, `OFS_CTRL, 32'h1);
    smp <= 10'h15A; // changed only while hold_o is low
    wb(1, `OFS_CTRL, 32'h3);
    conv_time(n);
    check("extended length", n, `FIRST_TICKS * `DIV_CYCLES);
    rd("new result", `OFS_RESULT, 32'h15A);
    wb(1, `OFS_STATUS, 32'h3);
    wb(1, `OFS_CTRL, 32'h7);
    wait_hold(1);
    pulse_sleep(SLP_NOISE);
    repeat (120) @(posedge clk);
    rd("free-run ctrl", `OFS_CTRL, 32'hF);
    rd("no sleep done", `OFS_STATUS, 1);
    pulse_ext();
    wb(1, `OFS_CTRL, 32'h1);
    wait_hold(0);
    $display("test restart_after_sleep done");
  endtask
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // reset, then the scenarios in order
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 0;
    soft_start_irq();
    noise_sleep_wake();
    other_irq_first();
    other_modes();
    restart_after_sleep();
    print_verdict();
  end
endmodule
`default_nettype wire
